// file: verilog/partial_instruction_execute.sv
// execution datapath for arithmetic, logic, bit, skip and jump instructions
`timescale 1ns/1ps
`include "exec_cfg.svh"
// Summary of operation
// [RL1] literal add: acc plus immediate into acc, all three flags updated
// [RL2] register add: acc plus file register, all three flags updated
// [RL3] destination bit 0 writes acc, 1 writes the file register back
// [RL4] clear one selected register bit, others and flags unchanged
// [RL5] set one selected register bit, others and flags unchanged
// [RL6] literal and: acc and immediate into acc, zero flag only
// [RL7] register and: routed by destination, zero flag only
// [RL8] bit clear test: skip next instruction as a nop, two cycles
// [RL9] decrement, route result, skip next on zero, no flags
// [RL10] jump loads pc low 11 bits and page latch bits into pc top
// [RL11] increment register, route result, zero flag only
// [RL12] increment, route result, skip next on zero, no flags
// [RL13] literal or: acc or immediate into acc, zero flag only
// [RL14] register or: routed by destination, zero flag only
// [RL15] zero, bit 7 carry and bit 3 carry flags set else cleared
module partial_instruction_execute #(
  parameter int REG_COUNT = 128
) (
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_reset, // async reset, active high
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic i_valid, // instruction present this cycle
  input wire exec_pkg::instr_t i_instr, // decoded instruction
  input wire logic [7:0] i_page_latch, // program_page_latch value
  output logic [7:0] o_acc, // accumulator
  output exec_pkg::flags_t o_flags, // status flags
  output logic [12:0] o_pc, // program counter
  output logic o_busy, // second cycle of a two-cycle instruction
  output logic o_wr_en, // file register written at the end of the previous cycle
  output logic [6:0] o_wr_addr, // file register write address
  output logic [7:0] o_wr_data // file register write data
);
  import exec_pkg::*;

  typedef enum logic {st_exec, st_flush} state_t;

  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] acc_q, acc_d;
  flags_t flags_q, flags_d;
  logic [12:0] pc_q, pc_d;
  state_t state_q, state_d;
  logic wr_en_q, wr_en_d;
  logic [6:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;

  logic [7:0] freg, lit, add_b, sum, res, bit_mask;
  logic carry, half, route, zero_skip;

  // operand selection for the shared adder
  always_comb
  begin
    freg = regs_q[i_instr.addr];
    lit = i_instr.imm[7:0];
    bit_mask = 8'h01 << i_instr.bit_sel;
    unique case (i_instr.op)
      op_add_literal_to_acc: add_b = lit;
      op_add_acc_and_reg: add_b = freg;
      default: add_b = 8'h00;
    endcase
  end

  exec_adder #(.WIDTH(8)) u_adder (
    .i_a(acc_q),
    .i_b(add_b),
    .o_sum(sum),
    .o_carry(carry),
    .o_half(half)
  );

  // result, destination and flag update for one instruction
  always_comb
  begin
    acc_d = acc_q;
    flags_d = flags_q;
    pc_d = pc_q;
    state_d = st_exec;
    wr_en_d = 1'b0;
    wr_addr_d = i_instr.addr;
    wr_data_d = wr_data_q;
    res = 8'h00;
    route = 1'b0;
    zero_skip = 1'b0;
    if (state_q == st_flush)
    begin
      // fetched word is discarded and a nop runs in its place
      pc_d = pc_q + 13'h0001; // RL8
    end
    else if (i_valid)
    begin
      pc_d = pc_q + 13'h0001;
      unique case (i_instr.op)
        op_nop:
        begin
          res = 8'h00;
        end
        op_add_literal_to_acc:
        begin
          acc_d = sum; // RL1
          flags_d.msb_spill_flag = carry; // RL15
          flags_d.nibble_spill_flag = half; // RL15
          flags_d.result_null_flag = (sum == 8'h00); // RL15
        end
        op_add_acc_and_reg:
        begin
          res = sum; // RL2
          route = 1'b1;
          flags_d.msb_spill_flag = carry; // RL15
          flags_d.nibble_spill_flag = half; // RL15
          flags_d.result_null_flag = (sum == 8'h00); // RL15
        end
        op_clear_reg_bit:
        begin
          wr_en_d = 1'b1;
          wr_data_d = freg & ~bit_mask; // RL4
        end
        op_set_reg_bit:
        begin
          wr_en_d = 1'b1;
          wr_data_d = freg | bit_mask; // RL5
        end
        op_and_literal_into_acc:
        begin
          acc_d = acc_q & lit; // RL6
          flags_d.result_null_flag = ((acc_q & lit) == 8'h00); // RL6
        end
        op_and_acc_with_reg:
        begin
          res = acc_q & freg; // RL7
          route = 1'b1;
          flags_d.result_null_flag = (res == 8'h00); // RL7
        end
        op_test_bit_skip_if_zero:
        begin
          if ((freg & bit_mask) == 8'h00)
          begin
            state_d = st_flush; // RL8
          end
        end
        op_decrement_skip_zero:
        begin
          res = freg - 8'h01; // RL9
          route = 1'b1;
          zero_skip = 1'b1;
        end
        op_absolute_jump:
        begin
          // page latch supplies the two top pc bits
          pc_d = {i_page_latch[`EXEC_PAGE_HI:`EXEC_PAGE_LO], i_instr.imm}; // RL10
          state_d = st_flush; // RL10
        end
        op_increment_reg:
        begin
          res = freg + 8'h01; // RL11
          route = 1'b1;
          flags_d.result_null_flag = (res == 8'h00); // RL11
        end
        op_increment_skip_zero:
        begin
          res = freg + 8'h01; // RL12
          route = 1'b1;
          zero_skip = 1'b1;
        end
        op_or_literal_into_acc:
        begin
          acc_d = acc_q | lit; // RL13
          flags_d.result_null_flag = ((acc_q | lit) == 8'h00); // RL13
        end
        op_or_acc_with_reg:
        begin
          res = acc_q | freg; // RL14
          route = 1'b1;
          flags_d.result_null_flag = (res == 8'h00); // RL14
        end
        default:
        begin
          res = 8'h00;
        end
      endcase
      if (route)
      begin
        if (i_instr.dest_reg)
        begin
          wr_en_d = 1'b1; // RL3
          wr_data_d = res;
        end
        else
        begin
          acc_d = res; // RL3
        end
      end
      if (zero_skip && res == 8'h00)
      begin
        state_d = st_flush; // RL9 RL12
      end
    end
  end

  // control registers; pc wraps modulo its width
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      acc_q <= `EXEC_ACC_RESET;
      flags_q <= `EXEC_FLAG_RESET;
      pc_q <= `EXEC_PC_RESET;
      state_q <= st_exec;
      wr_en_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end
    else if (i_ce)
    begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      state_q <= state_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // file registers have no reset; a write lands at the end of the execute cycle, with the acc update
  always_ff @(posedge i_mclk)
  begin
    if (i_ce && wr_en_d)
    begin
      regs_q[wr_addr_d] <= wr_data_d;
    end
  end

  assign o_acc = acc_q;
  assign o_flags = flags_q;
  assign o_pc = pc_q;
  assign o_busy = (state_q == st_flush);
  assign o_wr_en = wr_en_q;
  assign o_wr_addr = wr_addr_q;
  assign o_wr_data = wr_data_q;
endmodule

// file: verilog/exec_cfg.svh
// widths, field positions and reset values for the partial instruction execute block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define EXEC_DATA_W 8
`define EXEC_ADDR_W 7
`define EXEC_PC_W 13
`define EXEC_JUMP_W 11
`define EXEC_PAGE_HI 4
`define EXEC_PAGE_LO 3
`define EXEC_NIBBLE_BIT 3
`define EXEC_ACC_RESET 8'h00
`define EXEC_PC_RESET 13'h0000
`define EXEC_FLAG_RESET 3'h0
`endif

// file: verilog/exec_pkg.sv
// types shared by the partial instruction execute block
package exec_pkg;
  typedef enum logic [3:0] {
    op_nop,
    op_add_literal_to_acc,
    op_add_acc_and_reg,
    op_clear_reg_bit,
    op_set_reg_bit,
    op_and_literal_into_acc,
    op_and_acc_with_reg,
    op_test_bit_skip_if_zero,
    op_decrement_skip_zero,
    op_absolute_jump,
    op_increment_reg,
    op_increment_skip_zero,
    op_or_literal_into_acc,
    op_or_acc_with_reg
  } opcode_t;

  typedef struct packed {
    opcode_t op;
    logic [10:0] imm;
    logic [6:0] addr;
    logic [2:0] bit_sel;
    logic dest_reg;
  } instr_t;

  typedef struct packed {
    logic msb_spill_flag;
    logic nibble_spill_flag;
    logic result_null_flag;
  } flags_t;
endpackage

// file: verilog/exec_adder.sv
// 8-bit adder giving the sum and both spill carries
`timescale 1ns/1ps
module exec_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_a, // first operand
  input wire logic [WIDTH-1:0] i_b, // second operand
  output logic [WIDTH-1:0] o_sum, // sum
  output logic o_carry, // carry out of top bit
  output logic o_half // carry out of bit 3
);
  logic [WIDTH:0] full;
  logic [4:0] low;

  // low nibble summed apart so the half carry is exact
  always_comb
  begin
    full = {1'b0, i_a} + {1'b0, i_b};
    low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_sum = full[WIDTH-1:0];
    o_carry = full[WIDTH];
    o_half = low[4];
  end
endmodule

// file: sim/exec_chk.sv
// port assertions for the execute datapath
`timescale 1ns/1ps
module exec_chk import exec_pkg::*; (
  input wire logic i_mclk, // clock
  input wire logic i_reset, // async reset
  input wire logic i_ce, // enable
  input wire logic i_valid, // instr present
  input wire exec_pkg::instr_t i_instr, // instr
  input wire logic [7:0] i_page_latch, // page latch
  input wire logic [7:0] o_acc, // acc
  input wire exec_pkg::flags_t o_flags, // flags
  input wire logic [12:0] o_pc, // pc
  input wire logic o_busy, // flush cycle
  input wire logic o_wr_en, // write strobe
  input wire logic [6:0] o_wr_addr, // write addr
  input wire logic [7:0] o_wr_data // write data
);
  logic tk;
  opcode_t op;
  logic [7:0] k;
  // accepted instruction and its literal
  assign tk = i_ce && i_valid && !o_busy;
  assign op = i_instr.op;
  assign k = i_instr.imm[7:0];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  lit_add_a: assert property (tk && op == op_add_literal_to_acc |=> o_acc == $past(o_acc) + $past(k)
    && o_flags.msb_spill_flag == ({1'b0, $past(o_acc)} + $past(k) > 9'h0ff)) else $error("add bad");
  nib_flag_a: assert property (tk && op == op_add_literal_to_acc |=> o_flags.nibble_spill_flag
    == ({1'b0, $past(o_acc[3:0])} + $past(k[3:0]) > 5'h0f)) else $error("nibble flag bad");
  lit_and_a: assert property (tk && op == op_and_literal_into_acc |=> o_acc == ($past(o_acc)
    & $past(k)) && o_flags.result_null_flag == (o_acc == 8'h00) && $stable(o_flags.msb_spill_flag))
    else $error("and bad");
  lit_or_a: assert property (tk && op == op_or_literal_into_acc |=> o_acc == ($past(o_acc)
    | $past(k)) && o_flags.result_null_flag == (o_acc == 8'h00)) else $error("or bad");
  bit_op_a: assert property (tk && (op == op_set_reg_bit || op == op_clear_reg_bit) |=>
    $stable(o_flags) && o_wr_en && o_wr_addr == $past(i_instr.addr)
    && o_wr_data[$past(i_instr.bit_sel)] == $past(op == op_set_reg_bit)) else $error("bit op bad");
  dest_route_a: assert property (tk && op == op_add_acc_and_reg |=>
    o_wr_en == $past(i_instr.dest_reg)) else $error("dest bad");
  jump_load_a: assert property (tk && op == op_absolute_jump |=> o_busy
    && o_pc == {$past(i_page_latch[4:3]), $past(i_instr.imm)}) else $error("jump bad");
  flush_one_a: assert property (o_busy && i_ce && i_valid |=> !o_busy
    && o_pc == $past(o_pc) + 13'h1 && $stable(o_acc)) else $error("flush bad");
  skip_zero_a: assert property (tk && (op == op_decrement_skip_zero
    || op == op_increment_skip_zero) |=> $stable(o_flags)
    && o_busy == ((o_wr_en ? o_wr_data : o_acc) == 8'h00)) else $error("counting skip bad");
endmodule
bind partial_instruction_execute exec_chk i_exec_chk (.i_mclk, .i_reset, .i_ce, .i_valid,
  .i_instr, .i_page_latch, .o_acc, .o_flags, .o_pc, .o_busy, .o_wr_en, .o_wr_addr, .o_wr_data);

// file: sim/testbench.sv
// self-checking bench for the execute datapath
`timescale 1ns/1ps
module testbench;
  import exec_pkg::*;
  typedef struct packed {instr_t in; logic [7:0] acc; flags_t fl; logic [8:0] wr;} row_t;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_valid = 1'b0, o_busy, o_wr_en;
  instr_t i_instr = '0;
  logic [7:0] i_page_latch = 8'h18, o_acc, o_wr_data;
  flags_t o_flags;
  logic [12:0] o_pc, epc = 13'h0000;
  logic [6:0] o_wr_addr;
  int error_cnt = 0, samples_checked = 0;
  row_t rows [16];
  // free-running clock
  always #12.5 i_mclk = ~i_mclk;
  partial_instruction_execute i_partial_instruction_execute (.i_mclk, .i_reset, .i_ce, .i_valid,
    .i_instr, .i_page_latch, .o_acc, .o_flags, .o_pc, .o_busy, .o_wr_en, .o_wr_addr, .o_wr_data);
  // register 5 only, bd packs bit select above the destination bit
  function automatic instr_t ins(opcode_t o, logic [10:0] k, logic [3:0] bd);
    ins = '{o, k, 7'h05, bd[3:1], bd[0]};
  endfunction
  function automatic row_t r(opcode_t o, logic [7:0] k, logic [3:0] bd, logic [7:0] a,
    logic [2:0] f, logic [8:0] w);
    r = '{ins(o, {3'h0, k}, bd), a, f, w};
  endfunction
  task automatic chk(string n, logic [12:0] s, logic [12:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // drive at the falling edge, result is settled one cycle later
  task automatic step(instr_t x);
    i_instr = x;
    @(negedge i_mclk);
    epc = epc + 13'h1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // table run, then skips, jump, enable and reset by hand
  initial
  begin
    rows = '{r(op_and_acc_with_reg, 8'h00, 4'h1, 8'h00, 3'h1, 9'h100),
      r(op_add_literal_to_acc, 8'h8f, 4'h0, 8'h8f, 3'h0, 9'h000),
      r(op_add_literal_to_acc, 8'h71, 4'h0, 8'h00, 3'h7, 9'h000),
      r(op_or_literal_into_acc, 8'h3c, 4'h0, 8'h3c, 3'h6, 9'h000),
      r(op_add_acc_and_reg, 8'h00, 4'h1, 8'h3c, 3'h0, 9'h13c),
      r(op_set_reg_bit, 8'h00, 4'he, 8'h3c, 3'h0, 9'h1bc),
      r(op_clear_reg_bit, 8'h00, 4'h4, 8'h3c, 3'h0, 9'h1b8),
      r(op_and_literal_into_acc, 8'h0f, 4'h0, 8'h0c, 3'h0, 9'h000),
      r(op_or_acc_with_reg, 8'h00, 4'h0, 8'hbc, 3'h0, 9'h000),
      r(op_add_acc_and_reg, 8'h00, 4'h0, 8'h74, 3'h6, 9'h000),
      r(op_and_acc_with_reg, 8'h00, 4'h0, 8'h30, 3'h6, 9'h000),
      r(op_increment_reg, 8'h00, 4'h1, 8'h30, 3'h6, 9'h1b9),
      r(op_and_literal_into_acc, 8'h00, 4'h0, 8'h00, 3'h7, 9'h000),
      r(op_or_acc_with_reg, 8'h00, 4'h1, 8'h00, 3'h6, 9'h1b9),
      r(op_decrement_skip_zero, 8'h00, 4'h1, 8'h00, 3'h6, 9'h1b8),
      r(op_increment_skip_zero, 8'h00, 4'h0, 8'hb9, 3'h6, 9'h000)};
    repeat (3) @(negedge i_mclk);
    i_reset = 1'b0;
    i_valid = 1'b1;
    foreach (rows[i])
    begin
      step(rows[i].in);
      chk("acc", o_acc, rows[i].acc);
      chk("flags", o_flags, rows[i].fl);
      chk("write", {o_wr_en, o_wr_en ? o_wr_data : 8'h00}, rows[i].wr);
      chk("pc", o_pc, epc);
    end
    step(ins(op_test_bit_skip_if_zero, 11'h000, 4'h6));
    chk("busy", o_busy, 1'b0);
    step(ins(op_test_bit_skip_if_zero, 11'h000, 4'h0));
    chk("busy", o_busy, 1'b1);
    step(ins(op_add_literal_to_acc, 11'h055, 4'h0));
    chk("acc", o_acc, 8'hb9);
    chk("pc", o_pc, epc);
    step(ins(op_absolute_jump, 11'h7ff, 4'h0));
    epc = 13'h1fff;
    chk("pc", o_pc, epc);
    step(ins(op_nop, 11'h000, 4'h0));
    chk("pc", o_pc, epc);
    i_ce = 1'b0;
    step(ins(op_add_literal_to_acc, 11'h001, 4'h0));
    chk("acc", o_acc, 8'hb9);
    chk("pc", o_pc, 13'h0000);
    i_ce = 1'b1;
    // zero results of the counting skips: register 5 made 01, then 00, then ff
    step(ins(op_and_literal_into_acc, 11'h000, 4'h0));
    step(ins(op_and_acc_with_reg, 11'h000, 4'h1));
    step(ins(op_set_reg_bit, 11'h000, 4'h0));
    step(ins(op_decrement_skip_zero, 11'h000, 4'h1));
    chk("busy", o_busy, 1'b1);
    chk("write", {o_wr_en, o_wr_data}, 9'h100);
    step(ins(op_or_literal_into_acc, 11'h05a, 4'h0));
    chk("busy", o_busy, 1'b0);
    chk("acc", o_acc, 8'h00);
    step(ins(op_decrement_skip_zero, 11'h000, 4'h1));
    chk("busy", o_busy, 1'b0);
    chk("write", {o_wr_en, o_wr_data}, 9'h1ff);
    step(ins(op_or_literal_into_acc, 11'h05a, 4'h0));
    step(ins(op_increment_skip_zero, 11'h000, 4'h0));
    chk("acc", o_acc, 8'h00);
    chk("busy", o_busy, 1'b1);
    chk("flags", o_flags, 3'h6);
    // a jump fetched in the flush cycle must be thrown away
    step(ins(op_absolute_jump, 11'h7ff, 4'h0));
    chk("busy", o_busy, 1'b0);
    chk("acc", o_acc, 8'h00);
    // other page: only latch bits 4 and 3 reach the pc top
    i_page_latch = 8'h08;
    step(ins(op_absolute_jump, 11'h123, 4'h0));
    epc = 13'h0923;
    chk("pc", o_pc, epc);
    step(ins(op_nop, 11'h000, 4'h0));
    chk("pc", o_pc, epc);
    i_reset = 1'b1;
    @(negedge i_mclk);
    chk("reset", {o_acc, o_flags, o_busy, o_wr_en}, 13'h0000);
    chk("reset pc", o_pc, 13'h0000);
    finish_test;
  end
endmodule
